// ==== hw/aes_block_ctr_instruction_unit.sv ====
/*
 * Executes block-encrypt (plain, in place, xor) and counter-mode
 * instructions against the shared byte RAM, one engine, two priority slots.
 * Assumes the RAM answers a read strobe with data in the following cycle
 * and never stalls; the issuer is logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module aes_block_ctr_instruction_unit #(
	parameter int RAM_SIZE = aes_unit_pkg::RAM_BYTES
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic ISSUE_VALID,
	input wire logic [2:0] ISSUE_OP,
	input wire logic ISSUE_PRI,
	input wire logic [7:0] ISSUE_KEY,
	input wire logic [6:0] ISSUE_COUNT,
	input wire logic [7:0] ISSUE_CTR,
	input wire logic [11:0] ISSUE_SRC,
	input wire logic [11:0] ISSUE_DST,
	output logic RAM_RD,
	output logic RAM_WR,
	output logic [11:0] RAM_ADDR,
	output logic [7:0] RAM_WDATA,
	input wire logic [7:0] RAM_RDATA,
	output logic OVERLAP_USAGE_FAULT,
	output logic MEMORY_RANGE_FAULT,
	output logic LOW_PRIORITY_DONE_EVENT,
	output logic HIGH_PRIORITY_DONE_EVENT
);

	// the range check and 12-bit addressing cannot serve other sizes
	if (RAM_SIZE < 16 || RAM_SIZE > 4096) begin : g_size_check
		$error("RAM_SIZE must lie between 16 and 4096");
	end

	typedef enum logic [2:0] {
		S_IDLE, S_CHECK, S_KEY, S_BLK, S_GO, S_WAIT, S_OUT, S_FINISH
	} eng_state_t;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic fits(input logic [11:0] base,
		input logic [7:0] len);
		fits = ({1'b0, base} + {5'h00, len}) <= 13'(RAM_SIZE);
	endfunction : fits

	function automatic logic [11:0] slot_addr(input logic [7:0] idx);
		slot_addr = {idx, 4'h0};
	endfunction : slot_addr

	// ---------------------------------------------------------------
	// priority slots
	// ---------------------------------------------------------------
	logic [1:0] busy_q;
	logic [2:0] sl_op [2];
	logic [7:0] sl_key [2];
	logic [6:0] sl_cnt [2];
	logic [7:0] sl_ctr [2];
	logic [11:0] sl_src [2];
	logic [11:0] sl_dst [2];
	eng_state_t state_q;
	logic cur_pri_q;
	logic fin_now;

	assign fin_now = state_q == S_FINISH;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			busy_q <= 2'b00;
			OVERLAP_USAGE_FAULT <= 1'b0;
			LOW_PRIORITY_DONE_EVENT <= 1'b0;
			HIGH_PRIORITY_DONE_EVENT <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				sl_op[i] <= 3'h0;
				sl_key[i] <= 8'h00;
				sl_cnt[i] <= 7'h00;
				sl_ctr[i] <= 8'h00;
				sl_src[i] <= 12'h000;
				sl_dst[i] <= 12'h000;
			end
		end else begin
			OVERLAP_USAGE_FAULT <= ISSUE_VALID && busy_q[ISSUE_PRI];
			LOW_PRIORITY_DONE_EVENT <= fin_now && !cur_pri_q;
			HIGH_PRIORITY_DONE_EVENT <= fin_now && cur_pri_q;
			if (fin_now) begin
				busy_q[cur_pri_q] <= 1'b0;
			end
			// refused issue leaves the running slot untouched
			if (ISSUE_VALID && !busy_q[ISSUE_PRI]) begin
				busy_q[ISSUE_PRI] <= 1'b1;
				sl_op[ISSUE_PRI] <= ISSUE_OP;
				sl_key[ISSUE_PRI] <= ISSUE_KEY;
				sl_cnt[ISSUE_PRI] <= ISSUE_COUNT;
				sl_ctr[ISSUE_PRI] <= ISSUE_CTR;
				sl_src[ISSUE_PRI] <= ISSUE_SRC;
				sl_dst[ISSUE_PRI] <= ISSUE_DST;
			end
		end
	end

	// ---------------------------------------------------------------
	// engine
	// ---------------------------------------------------------------
	logic [2:0] cur_op_q;
	logic [7:0] cur_key_q;
	logic [6:0] cur_cnt_q;
	logic [7:0] cur_ctr_q;
	logic [11:0] cur_src_q;
	logic [11:0] cur_dst_q;
	logic [7:0] key_q [16];
	logic [7:0] blk_q [16];
	logic [3:0] idx_q;
	logic [1:0] ph_q;
	logic [6:0] pos_q;
	logic aes_start_q;
	logic aes_done;
	logic [127:0] key_vec;
	logic [127:0] blk_vec;
	logic [127:0] ct_vec;
	logic [7:0] ct_byte;
	logic is_ctr;
	logic is_xor;
	logic pad_byte;
	logic [7:0] src_len;
	logic [7:0] dst_len;
	logic range_ok;
	logic [15:0] ctr_next;
	logic pick;

	always_comb begin
		for (int i = 0; i < 16; i++) begin
			key_vec[127-8*i -: 8] = key_q[i];
			blk_vec[127-8*i -: 8] = blk_q[i];
		end
	end

	// counter decrypt shares the whole counter path
	assign is_ctr = cur_op_q == aes_unit_pkg::counter_encrypt_op
		|| cur_op_q == aes_unit_pkg::counter_decrypt_op;
	assign is_xor = cur_op_q == aes_unit_pkg::block_encrypt_xor_op;
	assign ct_byte = ct_vec[127-{idx_q, 3'h0} -: 8];
	assign pad_byte = !is_ctr
		&& ({1'b0, idx_q} >= 5'd16 - {1'b0, cur_cnt_q[3:0]});
	assign src_len = is_ctr ? {1'b0, cur_cnt_q}
		: (cur_op_q == aes_unit_pkg::block_encrypt_in_place_op) ? 8'd16
		: 8'd16 - {4'h0, cur_cnt_q[3:0]};
	assign dst_len = is_ctr ? {1'b0, cur_cnt_q} : 8'd16;
	assign range_ok = fits(slot_addr(cur_key_q), 8'd16)
		&& fits(cur_src_q, src_len) && fits(cur_dst_q, dst_len)
		&& (!is_ctr || fits(slot_addr(cur_ctr_q), 8'd16));
	assign ctr_next = {blk_q[aes_unit_pkg::CTR_FIELD_HI],
		blk_q[aes_unit_pkg::CTR_FIELD_LO]} + 16'h0001;
	assign pick = busy_q[1];

	aes128_round_core u_core (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.start(aes_start_q),
		.key(key_vec),
		.din(blk_vec),
		.done(aes_done),
		.dout(ct_vec)
	);

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state_q <= S_IDLE;
			cur_pri_q <= 1'b0;
			cur_op_q <= 3'h0;
			cur_key_q <= 8'h00;
			cur_cnt_q <= 7'h00;
			cur_ctr_q <= 8'h00;
			cur_src_q <= 12'h000;
			cur_dst_q <= 12'h000;
			idx_q <= 4'h0;
			ph_q <= 2'h0;
			pos_q <= 7'h00;
			aes_start_q <= 1'b0;
			RAM_RD <= 1'b0;
			RAM_WR <= 1'b0;
			RAM_ADDR <= 12'h000;
			RAM_WDATA <= 8'h00;
			MEMORY_RANGE_FAULT <= 1'b0;
			for (int i = 0; i < 16; i++) begin
				key_q[i] <= 8'h00;
				blk_q[i] <= 8'h00;
			end
		end else begin
			RAM_RD <= 1'b0;
			RAM_WR <= 1'b0;
			aes_start_q <= 1'b0;
			MEMORY_RANGE_FAULT <= 1'b0;
			case (state_q)
			S_IDLE: begin
				// high slot first; low waits behind a running high one
				if (busy_q != 2'b00) begin
					cur_pri_q <= pick;
					cur_op_q <= sl_op[pick];
					cur_key_q <= sl_key[pick];
					cur_cnt_q <= sl_cnt[pick];
					cur_ctr_q <= sl_ctr[pick];
					cur_src_q <= sl_src[pick];
					if (sl_op[pick] == aes_unit_pkg::block_encrypt_in_place_op
						|| (sl_op[pick] != aes_unit_pkg::block_encrypt_op
						&& sl_op[pick] != aes_unit_pkg::block_encrypt_xor_op
						&& sl_dst[pick] == 12'h000)) begin
						cur_dst_q <= sl_src[pick];
					end else begin
						cur_dst_q <= sl_dst[pick];
					end
					state_q <= S_CHECK;
				end
			end
			S_CHECK: begin
				idx_q <= 4'h0;
				ph_q <= 2'h0;
				pos_q <= 7'h00;
				if (!range_ok) begin
					MEMORY_RANGE_FAULT <= 1'b1;
					state_q <= S_FINISH;
				end else if (is_ctr && cur_cnt_q == 7'h00) begin
					state_q <= S_FINISH;
				end else begin
					state_q <= S_KEY;
				end
			end
			S_KEY: begin
				case (ph_q)
				2'h0: begin
					RAM_RD <= 1'b1;
					RAM_ADDR <= slot_addr(cur_key_q) + {8'h00, idx_q};
					ph_q <= 2'h1;
				end
				2'h1: begin
					ph_q <= 2'h2;
				end
				default: begin
					key_q[idx_q] <= RAM_RDATA;
					ph_q <= 2'h0;
					idx_q <= idx_q + 4'h1;
					if (idx_q == 4'hf) begin
						state_q <= S_BLK;
					end
				end
				endcase
			end
			S_BLK: begin
				case (ph_q)
				2'h0: begin
					if (pad_byte) begin
						blk_q[idx_q] <= 8'h00;
						idx_q <= idx_q + 4'h1;
						if (idx_q == 4'hf) begin
							state_q <= S_GO;
						end
					end else begin
						RAM_RD <= 1'b1;
						RAM_ADDR <= (is_ctr ? slot_addr(cur_ctr_q) : cur_src_q)
							+ {8'h00, idx_q};
						ph_q <= 2'h1;
					end
				end
				2'h1: begin
					ph_q <= 2'h2;
				end
				default: begin
					blk_q[idx_q] <= RAM_RDATA;
					ph_q <= 2'h0;
					idx_q <= idx_q + 4'h1;
					if (idx_q == 4'hf) begin
						state_q <= S_GO;
					end
				end
				endcase
			end
			S_GO: begin
				aes_start_q <= 1'b1;
				state_q <= S_WAIT;
			end
			S_WAIT: begin
				idx_q <= 4'h0;
				ph_q <= 2'h0;
				if (aes_done) begin
					state_q <= S_OUT;
				end
			end
			S_OUT: begin
				if (!is_ctr && !is_xor) begin
					RAM_WR <= 1'b1;
					RAM_ADDR <= cur_dst_q + {8'h00, idx_q};
					RAM_WDATA <= ct_byte;
					idx_q <= idx_q + 4'h1;
					if (idx_q == 4'hf) begin
						state_q <= S_FINISH;
					end
				end else begin
					case (ph_q)
					2'h0: begin
						RAM_RD <= 1'b1;
						RAM_ADDR <= is_ctr ? cur_src_q + {5'h00, pos_q}
							: cur_dst_q + {8'h00, idx_q};
						ph_q <= 2'h1;
					end
					2'h1: begin
						ph_q <= 2'h2;
					end
					default: begin
						RAM_WR <= 1'b1;
						RAM_WDATA <= RAM_RDATA ^ ct_byte;
						RAM_ADDR <= is_ctr ? cur_dst_q + {5'h00, pos_q}
							: cur_dst_q + {8'h00, idx_q};
						ph_q <= 2'h0;
						idx_q <= idx_q + 4'h1;
						pos_q <= pos_q + 7'h01;
						if (is_ctr && pos_q + 7'h01 == cur_cnt_q) begin
							state_q <= S_FINISH;
						end else if (idx_q == 4'hf) begin
							if (is_ctr) begin
								// next keystream block, 16-bit counter field
								blk_q[aes_unit_pkg::CTR_FIELD_HI] <= ctr_next[15:8];
								blk_q[aes_unit_pkg::CTR_FIELD_LO] <= ctr_next[7:0];
								state_q <= S_GO;
							end else begin
								state_q <= S_FINISH;
							end
						end
					end
					endcase
				end
			end
			S_FINISH: begin
				state_q <= S_IDLE;
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end

endmodule : aes_block_ctr_instruction_unit

`default_nettype wire

// ==== include/aes_unit_pkg.sv ====
/*
 * Shared constants of the AES-128 instruction unit: memory size, block
 * geometry, instruction codes and cipher constants.
 * Assumes a byte-wide on-chip RAM shared with other masters.
 */
package aes_unit_pkg;

	// ---------------------------------------------------------------
	// memory and block geometry
	// ---------------------------------------------------------------
	localparam int RAM_BYTES = 768;
	localparam int BLOCK_BYTES = 16;
	localparam int SLOT_SHIFT = 4;
	localparam int CTR_FIELD_HI = 14;
	localparam int CTR_FIELD_LO = 15;

	// ---------------------------------------------------------------
	// instruction codes on the issue port
	// ---------------------------------------------------------------
	localparam logic [2:0] block_encrypt_op = 3'h0;
	localparam logic [2:0] block_encrypt_in_place_op = 3'h1;
	localparam logic [2:0] block_encrypt_xor_op = 3'h2;
	localparam logic [2:0] counter_encrypt_op = 3'h3;
	localparam logic [2:0] counter_decrypt_op = 3'h4;

	// ---------------------------------------------------------------
	// cipher constants
	// ---------------------------------------------------------------
	localparam int AES_ROUNDS = 10;
	localparam logic [7:0] RCON_INIT = 8'h01;
	localparam logic [7:0] REDUCE_POLY = 8'h1b;
	localparam logic [7:0] AFFINE_CONST = 8'h63;

endpackage : aes_unit_pkg

// ==== hw/aes128_round_core.sv ====
/*
 * Iterative AES-128 encryptor, one round per clock, key expanded on the fly.
 * Assumes start is a one-cycle pulse given only while idle; byte 0 of a
 * block sits in bits 127:120.
 */
`timescale 1ns/1ps
`default_nettype none

module aes128_round_core (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [127:0] key,
	input wire logic [127:0] din,
	output logic done,
	output logic [127:0] dout
);

	// ---------------------------------------------------------------
	// field arithmetic
	// ---------------------------------------------------------------
	function automatic logic [7:0] xt(input logic [7:0] b);
		xt = {b[6:0], 1'b0} ^ (b[7] ? aes_unit_pkg::REDUCE_POLY : 8'h00);
	endfunction : xt

	function automatic logic [7:0] gmul(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				p = p ^ x;
			end
			x = xt(x);
		end
		gmul = p;
	endfunction : gmul

	// inverse as x^254, so zero maps to zero without a special case
	function automatic logic [7:0] sbox(input logic [7:0] x);
		logic [7:0] p;
		logic [7:0] r;
		p = x;
		r = 8'h01;
		for (int i = 1; i < 8; i++) begin
			p = gmul(p, p);
			r = gmul(r, p);
		end
		sbox = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
			^ {r[3:0], r[7:4]} ^ aes_unit_pkg::AFFINE_CONST;
	endfunction : sbox

	function automatic logic [127:0] expand(input logic [127:0] k,
		input logic [7:0] rc);
		logic [31:0] w3;
		logic [31:0] t;
		logic [31:0] n0;
		logic [31:0] n1;
		logic [31:0] n2;
		w3 = k[31:0];
		t = {sbox(w3[23:16]) ^ rc, sbox(w3[15:8]), sbox(w3[7:0]),
			sbox(w3[31:24])};
		n0 = k[127:96] ^ t;
		n1 = k[95:64] ^ n0;
		n2 = k[63:32] ^ n1;
		expand = {n0, n1, n2, w3 ^ n2};
	endfunction : expand

	function automatic logic [127:0] do_round(input logic [127:0] s,
		input logic [127:0] k, input logic last);
		logic [7:0] sb [16];
		logic [7:0] sr [16];
		logic [7:0] a [4];
		logic [127:0] o;
		for (int i = 0; i < 16; i++) begin
			sb[i] = sbox(s[127-8*i -: 8]);
		end
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 4; r++) begin
				sr[c*4+r] = sb[((c+r)%4)*4+r];
			end
		end
		o = '0;
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 4; r++) begin
				a[r] = sr[c*4+r];
			end
			for (int r = 0; r < 4; r++) begin
				o[127-8*(c*4+r) -: 8] = last ? a[r] : (xt(a[r])
					^ xt(a[(r+1)%4]) ^ a[(r+1)%4] ^ a[(r+2)%4] ^ a[(r+3)%4]);
			end
		end
		do_round = o ^ k;
	endfunction : do_round

	// ---------------------------------------------------------------
	// round sequencing
	// ---------------------------------------------------------------
	logic [127:0] rk_q;
	logic [127:0] rk_d;
	logic [7:0] rcon_q;
	logic [3:0] round_q;
	logic running_q;

	assign rk_d = expand(rk_q, rcon_q);

	always_ff @(posedge clk) begin
		if (rst) begin
			running_q <= 1'b0;
			round_q <= 4'h0;
			done <= 1'b0;
			dout <= '0;
			rk_q <= '0;
			rcon_q <= aes_unit_pkg::RCON_INIT;
		end else begin
			done <= 1'b0;
			if (start) begin
				dout <= din ^ key;
				rk_q <= key;
				rcon_q <= aes_unit_pkg::RCON_INIT;
				round_q <= 4'h1;
				running_q <= 1'b1;
			end else if (running_q) begin
				dout <= do_round(dout, rk_d,
					round_q == 4'(aes_unit_pkg::AES_ROUNDS));
				rk_q <= rk_d;
				rcon_q <= xt(rcon_q);
				round_q <= round_q + 4'h1;
				if (round_q == 4'(aes_unit_pkg::AES_ROUNDS)) begin
					running_q <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule : aes128_round_core

`default_nettype wire

// ==== test/aes_unit_chk.sv ====
/*
 * Port checker of the AES instruction unit.
 * Assumes one clock domain; bound to the unit from the testbench top.
 */
`timescale 1ns/1ps
`default_nettype none

module aes_unit_chk #(
	parameter int RAM_SIZE = 768
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic ISSUE_VALID,
	input wire logic RAM_RD,
	input wire logic RAM_WR,
	input wire logic [11:0] RAM_ADDR,
	input wire logic OVERLAP_USAGE_FAULT,
	input wire logic MEMORY_RANGE_FAULT,
	input wire logic LOW_PRIORITY_DONE_EVENT,
	input wire logic HIGH_PRIORITY_DONE_EVENT
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	logic done_any;
	logic acc;
	assign done_any = LOW_PRIORITY_DONE_EVENT | HIGH_PRIORITY_DONE_EVENT;
	assign acc = RAM_RD | RAM_WR;
	// ---------------------------------------------------------------
	// bus and event relations
	// ---------------------------------------------------------------
	chk_bus_excl: assert property (!(RAM_RD && RAM_WR))
		else $error("read and write strobes together");
	chk_rd_spacing: assert property (RAM_RD |=> !RAM_RD [*2])
		else $error("read strobes closer than three cycles");
	chk_addr_inside: assert property (acc |-> RAM_ADDR < RAM_SIZE)
		else $error("ram access outside memory");
	chk_usage_cause: assert property (
		OVERLAP_USAGE_FAULT |-> $past(ISSUE_VALID))
		else $error("usage fault without an issue");
	chk_done_single: assert property (
		!(LOW_PRIORITY_DONE_EVENT && HIGH_PRIORITY_DONE_EVENT))
		else $error("both done events at once");
	chk_done_pulse: assert property (done_any |=> !done_any)
		else $error("done event longer than one cycle");
	chk_range_done: assert property (
		MEMORY_RANGE_FAULT |=> done_any)
		else $error("range fault not followed by done");
	chk_range_quiet: assert property (
		MEMORY_RANGE_FAULT |-> !acc ##1 !acc)
		else $error("ram touched around a range fault");
	// reset itself must not mask this one
	chk_reset_quiet: assert property (
		disable iff (1'b0) SYS_RST |=> !(acc ||
		OVERLAP_USAGE_FAULT || MEMORY_RANGE_FAULT || done_any))
		else $error("outputs active after reset edge");
	cov_range: cover property (MEMORY_RANGE_FAULT);
	cov_usage: cover property (OVERLAP_USAGE_FAULT);
	cov_high: cover property (HIGH_PRIORITY_DONE_EVENT);
endmodule : aes_unit_chk

`default_nettype wire

// ==== test/ram_model.sv ====
/*
 * Byte RAM partner of the unit, with access counters for the bench.
 * Assumes read data is wanted only the cycle after a read strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module ram_model #(
	parameter int SIZE = 768
) (
	input wire logic clk,
	input wire logic rd,
	input wire logic wr,
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:SIZE-1];
	int n_rd = 0;
	int n_wr = 0;
	initial rdata = 8'h00;
	// outside the answer cycle the data toggles, so stale bytes never match
	always @(posedge clk) begin
		rdata <= ~rdata;
		if (rd) begin
			n_rd <= n_rd + 1;
			rdata <= (addr < SIZE) ? mem[addr] : 8'h5a;
		end
		if (wr) begin
			n_wr <= n_wr + 1;
			if (addr < SIZE) mem[addr] <= wdata;
		end
	end
endmodule : ram_model

`default_nettype wire

// ==== test/tb.sv ====
/*
 * Self-checking bench of the AES instruction unit with a RAM model.
 * Assumes the standard AES-128 test vector for key, block and cipher.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
	localparam logic [127:0] PT = 128'h00112233445566778899aabbccddeeff;
	localparam logic [127:0] CT = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
	logic CORE_CLK = 1'b0, SYS_RST = 1'b1, ISSUE_VALID = 1'b0, ISSUE_PRI = 1'b0;
	logic [2:0] ISSUE_OP = 3'h0;
	logic [7:0] ISSUE_KEY = 8'h00, ISSUE_CTR = 8'h00;
	logic [6:0] ISSUE_COUNT = 7'h00;
	logic [11:0] ISSUE_SRC = 12'h000, ISSUE_DST = 12'h000;
	logic RAM_RD, RAM_WR, OVERLAP_USAGE_FAULT, MEMORY_RANGE_FAULT;
	logic LOW_PRIORITY_DONE_EVENT, HIGH_PRIORITY_DONE_EVENT;
	logic [11:0] RAM_ADDR;
	logic [7:0] RAM_WDATA, RAM_RDATA;
	int err_total = 0, n_compared = 0, cyc = 0;
	int n_lo = 0, n_hi = 0, n_uf = 0, n_rf = 0;

	aes_block_ctr_instruction_unit #(.RAM_SIZE(768)) u_dut (
		.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .ISSUE_VALID(ISSUE_VALID),
		.ISSUE_OP(ISSUE_OP), .ISSUE_PRI(ISSUE_PRI), .ISSUE_KEY(ISSUE_KEY),
		.ISSUE_COUNT(ISSUE_COUNT), .ISSUE_CTR(ISSUE_CTR),
		.ISSUE_SRC(ISSUE_SRC), .ISSUE_DST(ISSUE_DST), .RAM_RD(RAM_RD),
		.RAM_WR(RAM_WR), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA),
		.RAM_RDATA(RAM_RDATA), .OVERLAP_USAGE_FAULT(OVERLAP_USAGE_FAULT),
		.MEMORY_RANGE_FAULT(MEMORY_RANGE_FAULT),
		.LOW_PRIORITY_DONE_EVENT(LOW_PRIORITY_DONE_EVENT),
		.HIGH_PRIORITY_DONE_EVENT(HIGH_PRIORITY_DONE_EVENT));
	ram_model #(.SIZE(768)) u_ram (.clk(CORE_CLK), .rd(RAM_RD), .wr(RAM_WR),
		.addr(RAM_ADDR), .wdata(RAM_WDATA), .rdata(RAM_RDATA));

	initial forever #12.5 CORE_CLK = ~CORE_CLK;
	// ---------------------------------------------------------------
	// event counters and hang guard
	// ---------------------------------------------------------------
	always @(posedge CORE_CLK) begin
		cyc++;
		if (LOW_PRIORITY_DONE_EVENT === 1'b1) n_lo++;
		if (HIGH_PRIORITY_DONE_EVENT === 1'b1) n_hi++;
		if (OVERLAP_USAGE_FAULT === 1'b1) n_uf++;
		if (MEMORY_RANGE_FAULT === 1'b1) n_rf++;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s exp %h got %h", what, exp, got);
		end
	endtask : cmp8
	task automatic cmpn(string what, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s exp %0d got %0d", what, exp, got);
		end
	endtask : cmpn
	task automatic load(int a, logic [127:0] v);
		for (int i = 0; i < 16; i++) u_ram.mem[a+i] = v[127-8*i -: 8];
	endtask : load
	task automatic chk_blk(string what, int a, logic [127:0] v, int n);
		for (int i = 0; i < n; i++) cmp8(what, v[127-8*i -: 8], u_ram.mem[a+i]);
	endtask : chk_blk
	task automatic issue(logic [2:0] op, logic p, logic [7:0] k,
		logic [6:0] c, logic [11:0] a, logic [11:0] e);
		@(posedge CORE_CLK);
		ISSUE_VALID <= 1'b1;
		ISSUE_OP <= op;
		ISSUE_PRI <= p;
		ISSUE_KEY <= k;
		ISSUE_COUNT <= c;
		ISSUE_CTR <= 8'h02;
		ISSUE_SRC <= a;
		ISSUE_DST <= e;
		@(posedge CORE_CLK);
		ISSUE_VALID <= 1'b0;
	endtask : issue
	task automatic wait_ev(int lo, int hi);
		for (int i = 0; i < 3000 && (n_lo < lo || n_hi < hi); i++)
			@(posedge CORE_CLK);
		repeat (4) @(posedge CORE_CLK);
	endtask : wait_ev
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_block;
		int lo;
		int hi;
		lo = n_lo;
		hi = n_hi;
		load(16, KEY);
		load(64, PT);
		issue(aes_unit_pkg::block_encrypt_op, 1'b0, 8'h01, 7'h00, 12'h040, 12'h080);
		wait_ev(lo + 1, hi);
		chk_blk("plain block", 128, CT, 16);
		cmpn("low done", lo + 1, n_lo);
		issue(aes_unit_pkg::block_encrypt_in_place_op, 1'b1, 8'h01, 7'h00,
			12'h040, 12'h000);
		wait_ev(lo + 1, hi + 1);
		chk_blk("in place", 64, CT, 16);
		cmpn("high done", hi + 1, n_hi);
		load(64, PT);
		load(128, {16{8'ha5}});
		issue(aes_unit_pkg::block_encrypt_xor_op, 1'b0, 8'h01, 7'h00,
			12'h040, 12'h080);
		wait_ev(lo + 2, hi + 1);
		chk_blk("xor block", 128, CT ^ {16{8'ha5}}, 16);
		$display("test block variants finished");
	endtask : t_block
	task automatic t_pad;
		int r;
		int w;
		int lo;
		for (int c = 4; c < 16; c += 11) begin
			r = u_ram.n_rd;
			w = u_ram.n_wr;
			lo = n_lo;
			issue(aes_unit_pkg::block_encrypt_op, 1'b0, 8'h01, c[6:0],
				12'h040, 12'h080);
			wait_ev(lo + 1, 0);
			cmpn("pad reads", 32 - c, u_ram.n_rd - r);
			cmpn("pad writes", 16, u_ram.n_wr - w);
		end
		$display("test padding counts finished");
	endtask : t_pad
	task automatic t_ctr;
		int lo;
		lo = n_lo;
		load(32, PT);
		load(192, 128'h0);
		load(256, {16{8'hee}});
		issue(aes_unit_pkg::counter_encrypt_op, 1'b0, 8'h01, 7'h10,
			12'h0c0, 12'h000);
		wait_ev(lo + 1, 0);
		chk_blk("ctr in place", 192, CT, 16);
		issue(aes_unit_pkg::counter_decrypt_op, 1'b0, 8'h01, 7'h05,
			12'h0c0, 12'h100);
		wait_ev(lo + 2, 0);
		chk_blk("ctr decrypt", 256, 128'h0, 5);
		cmp8("ctr length", 8'hee, u_ram.mem[261]);
		// counter one below the vector: the second block must yield CT
		load(32, PT - 128'h1);
		load(192, 128'h0);
		load(208, 128'h0);
		issue(aes_unit_pkg::counter_encrypt_op, 1'b0, 8'h01, 7'h20,
			12'h0c0, 12'h100);
		wait_ev(lo + 3, 0);
		chk_blk("ctr second block", 272, CT, 16);
		$display("test counter mode finished");
	endtask : t_ctr
	task automatic t_overlap;
		int lo;
		int hi;
		int uf;
		lo = n_lo;
		hi = n_hi;
		uf = n_uf;
		issue(aes_unit_pkg::block_encrypt_op, 1'b0, 8'h01, 7'h00, 12'h040, 12'h080);
		issue(aes_unit_pkg::block_encrypt_op, 1'b0, 8'h01, 7'h00, 12'h040, 12'h080);
		issue(aes_unit_pkg::block_encrypt_op, 1'b1, 8'h01, 7'h00, 12'h040, 12'h0a0);
		wait_ev(lo + 1, hi + 1);
		repeat (200) @(posedge CORE_CLK);
		cmpn("usage faults", uf + 1, n_uf);
		cmpn("low done once", lo + 1, n_lo);
		cmpn("high done", hi + 1, n_hi);
		$display("test overlap finished");
	endtask : t_overlap
	task automatic t_range;
		int r;
		int rf;
		int hi;
		logic [7:0] k [2];
		logic [11:0] a [2];
		k = '{8'h01, 8'h30};
		a = '{12'h2f8, 12'h040};
		for (int i = 0; i < 2; i++) begin
			r = u_ram.n_rd;
			rf = n_rf;
			hi = n_hi;
			issue(aes_unit_pkg::block_encrypt_op, 1'b1, k[i], 7'h00, a[i], 12'h080);
			wait_ev(0, hi + 1);
			cmpn("range fault", rf + 1, n_rf);
			cmpn("range done", hi + 1, n_hi);
			cmpn("range reads", 0, u_ram.n_rd - r);
		end
		$display("test range fault finished");
	endtask : t_range
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	initial begin
		repeat (3) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		t_block();
		t_pad();
		t_ctr();
		t_overlap();
		t_range();
		summarize();
	end
endmodule : tb

bind aes_block_ctr_instruction_unit aes_unit_chk #(.RAM_SIZE(RAM_SIZE)) u_chk (
	.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .ISSUE_VALID(ISSUE_VALID),
	.RAM_RD(RAM_RD), .RAM_WR(RAM_WR), .RAM_ADDR(RAM_ADDR),
	.OVERLAP_USAGE_FAULT(OVERLAP_USAGE_FAULT),
	.MEMORY_RANGE_FAULT(MEMORY_RANGE_FAULT),
	.LOW_PRIORITY_DONE_EVENT(LOW_PRIORITY_DONE_EVENT),
	.HIGH_PRIORITY_DONE_EVENT(HIGH_PRIORITY_DONE_EVENT));

`default_nettype wire
